// >>> rtl/ceiu_core.sv
// Purpose: exception entry, return, reset and interrupt sampling of the core
// Assumes: pipeline flags instruction boundaries with instr_end
// Notes: registers reached over Avalon-MM, answer on the second edge
`timescale 1ns/1ps
`include "ceiu_regs.svh"
module ceiu_core (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic core_reset_n,
   input wire logic big_endian_init_pin,
   input wire logic unaligned_enable_init_pin,
   input wire logic fast_irq_request_n,
   input wire logic normal_irq_request_n,
   input wire logic instr_end,
   input wire logic [31:0] next_pc,
   input wire logic data_abort,
   input wire logic [31:0] abort_pc,
   input wire logic ret_valid,
   input wire logic ret_data_op,
   input wire logic ret_set_flags,
   input wire logic ret_dest_pc,
   input wire logic mw_device_busy,
   input wire logic restartable_busy,
   input wire logic [31:0] vic_addr,
   input wire logic vic_addr_valid,
   input wire logic [`CEIU_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [31:0] current_status_word,
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   output logic abandon_instr,
   output logic hit_under_miss_disable,
   output logic abandon_restartable,
   output logic int_pending,
   output logic vic_addr_req,
   output logic vic_ack,
   output logic vic_done
);
   ceiu_pkg::ceiu_state_t state;
   ceiu_pkg::ceiu_state_t next_state;
   logic fiq_sync_n;
   logic irq_sync_n;
   logic rst_sync_n;
   logic [1:0] pins_sync;
   logic fiq_late_n;
   logic irq_late_n;
   logic fiq_seen;
   logic irq_seen;
   logic [31:0] ctrl;
   logic [31:0] saved [0:3];
   logic [31:0] link [0:2];
   logic [31:0] chain_pc;
   logic low_latency_enable;
   logic vectored_irq_enable;
   logic boundary;
   logic take_abt;
   logic take_fiq;
   logic take_irq;
   logic ent_any;
   logic ent_irq;
   logic release_now;
   logic ret_now;
   logic [31:0] next_status;
   logic [31:0] ent_link;
   logic [31:0] ent_vec;
   ceiu_pkg::ceiu_bank_t ent_bank;
   ceiu_pkg::ceiu_bank_t cur_bank;
   logic bus_ack;
   logic wr_now;
   logic [31:0] wmask;
   logic [31:0] rd_mux;

   // Interrupt lines idle high, so synchronisers start high
   ceiu_sync #(.W(2), .INIT(2'b11)) u_int_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .d({fast_irq_request_n, normal_irq_request_n}),
      .q({fiq_sync_n, irq_sync_n})
   );

   ceiu_sync #(.W(3), .INIT(3'b000)) u_pin_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .d({core_reset_n, big_endian_init_pin, unaligned_enable_init_pin}),
      .q({rst_sync_n, pins_sync})
   );

   // Extra stage models the later sampling point of the normal configuration
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fiq_late_n <= 1'b1;
         irq_late_n <= 1'b1;
      end else if (ce) begin
         fiq_late_n <= fiq_sync_n;
         irq_late_n <= irq_sync_n;
      end
   end

   assign low_latency_enable = ctrl[`CEIU_CTRL_LL_BIT];
   assign vectored_irq_enable = ctrl[`CEIU_CTRL_VE_BIT];
   // Low latency reads the freshest registered sample
   assign fiq_seen = low_latency_enable ? ~fiq_sync_n : ~fiq_late_n;
   assign irq_seen = low_latency_enable ? ~irq_sync_n : ~irq_late_n;

   assign int_pending = (fiq_seen & ~current_status_word[`CEIU_ST_F_BIT])
      | (irq_seen & ~current_status_word[`CEIU_ST_I_BIT]);
   assign abandon_restartable = low_latency_enable & int_pending & restartable_busy;
   assign abandon_instr = ~rst_sync_n;
   assign vic_addr_req = (state == ceiu_pkg::S_VIC);

   assign boundary = rst_sync_n & (((state == ceiu_pkg::S_RUN) & instr_end)
      | (state == ceiu_pkg::S_CHAIN));

   ceiu_entry_arb u_arb (
      .boundary(boundary),
      .data_abort(data_abort & (state == ceiu_pkg::S_RUN)),
      .fiq_req(fiq_seen),
      .irq_req(irq_seen),
      .fiq_mask(current_status_word[`CEIU_ST_F_BIT]),
      .irq_mask(current_status_word[`CEIU_ST_I_BIT]),
      .int_hold(mw_device_busy),
      .take_abt(take_abt),
      .take_fiq(take_fiq),
      .take_irq(take_irq)
   );

   // Without the enable the fixed vector is used, no controller handshake
   assign ent_irq = (take_irq & ~vectored_irq_enable)
      | ((state == ceiu_pkg::S_VIC) & vic_addr_valid & rst_sync_n);
   assign ent_any = take_abt | take_fiq | ent_irq;
   assign release_now = (state == ceiu_pkg::S_RESET) & rst_sync_n;
   assign ret_now = rst_sync_n & ret_valid & ret_data_op & ret_set_flags & ret_dest_pc;

   function automatic ceiu_pkg::ceiu_bank_t mode_bank(input logic [4:0] m);
      case (m)
         `CEIU_MODE_FIQ: mode_bank = ceiu_pkg::BANK_FIQ;
         `CEIU_MODE_IRQ: mode_bank = ceiu_pkg::BANK_IRQ;
         `CEIU_MODE_ABT: mode_bank = ceiu_pkg::BANK_ABT;
         default: mode_bank = ceiu_pkg::BANK_SVC;
      endcase
   endfunction

   assign cur_bank = mode_bank(current_status_word[4:0]);

   // Entry target: mode, masks, link and vector
   always_comb begin
      next_status = current_status_word;
      next_status[`CEIU_ST_T_BIT] = 1'b0;
      next_status[`CEIU_ST_J_BIT] = 1'b0;
      next_status[`CEIU_ST_I_BIT] = 1'b1;
      ent_bank = ceiu_pkg::BANK_IRQ;
      ent_link = next_pc + `CEIU_LINK_OFS_INT;
      ent_vec = vectored_irq_enable ? vic_addr : `CEIU_VEC_IRQ;
      if (take_abt) begin
         next_status[4:0] = `CEIU_MODE_ABT;
         next_status[`CEIU_ST_A_BIT] = 1'b1;
         ent_bank = ceiu_pkg::BANK_ABT;
         ent_link = abort_pc + `CEIU_LINK_OFS_DABT;
         ent_vec = `CEIU_VEC_DABT;
      end else if (take_fiq) begin
         next_status[4:0] = `CEIU_MODE_FIQ;
         next_status[`CEIU_ST_F_BIT] = 1'b1;
         ent_bank = ceiu_pkg::BANK_FIQ;
         // After an abort entry the interrupted instruction is the abort vector
         ent_link = ((state == ceiu_pkg::S_CHAIN) ? chain_pc : next_pc)
            + `CEIU_LINK_OFS_INT;
         ent_vec = `CEIU_VEC_FIQ;
      end else begin
         next_status[4:0] = `CEIU_MODE_IRQ;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ceiu_pkg::S_RESET: begin
            if (rst_sync_n) begin
               next_state = ceiu_pkg::S_RUN;
            end
         end
         ceiu_pkg::S_RUN: begin
            if (take_abt) begin
               next_state = ceiu_pkg::S_CHAIN;
            end else if (take_irq & vectored_irq_enable) begin
               next_state = ceiu_pkg::S_VIC;
            end
         end
         ceiu_pkg::S_CHAIN: next_state = ceiu_pkg::S_RUN;
         ceiu_pkg::S_VIC: begin
            if (vic_addr_valid) begin
               next_state = ceiu_pkg::S_RUN;
            end
         end
         default: next_state = ceiu_pkg::S_RESET;
      endcase
      if (!rst_sync_n) begin
         next_state = ceiu_pkg::S_RESET;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= ceiu_pkg::S_RESET;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Current status word: reset, entry, return, then software mask writes
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         current_status_word <= `CEIU_ST_RESET;
      end else if (ce) begin
         if (!rst_sync_n) begin
            current_status_word <= `CEIU_ST_RESET;
         end else if (release_now) begin
            current_status_word <= `CEIU_ST_RESET;
            current_status_word[`CEIU_ST_E_BIT] <= pins_sync[1];
            current_status_word[`CEIU_ST_U_BIT] <= pins_sync[0];
         end else if (ent_any) begin
            current_status_word <= next_status;
         end else if (ret_now) begin
            current_status_word <= saved[cur_bank];
         end else if (wr_now && {avs_address[`CEIU_ADDR_W-1:2], 2'b00} == `CEIU_OFF_STATUS) begin
            // Software may only move the three mask bits
            current_status_word[`CEIU_ST_F_BIT] <= avs_writedata[`CEIU_ST_F_BIT];
            current_status_word[`CEIU_ST_I_BIT] <= avs_writedata[`CEIU_ST_I_BIT];
            current_status_word[`CEIU_ST_A_BIT] <= avs_writedata[`CEIU_ST_A_BIT];
         end
      end
   end

   // Saved status words and links; cleared to zero by reset until first entry
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int k = 0; k < 4; k++) begin
            saved[k] <= 32'h0000_0000;
         end
         for (int k = 0; k < 3; k++) begin
            link[k] <= 32'h0000_0000;
         end
         chain_pc <= 32'h0000_0000;
      end else if (ce && rst_sync_n && ent_any) begin
         saved[ent_bank] <= current_status_word;
         link[ent_bank] <= ent_link;
         chain_pc <= ent_vec;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fetch_req <= 1'b0;
         fetch_addr <= `CEIU_VEC_RESET;
         vic_ack <= 1'b0;
      end else if (ce) begin
         fetch_req <= release_now | ent_any;
         vic_ack <= ent_irq & (state == ceiu_pkg::S_VIC);
         if (release_now) begin
            fetch_addr <= `CEIU_VEC_RESET;
         end else if (ent_any) begin
            fetch_addr <= ent_vec;
         end
      end
   end

   // Avalon slave: request taken on the edge where waitrequest is low
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
   assign wr_now = avs_write & bus_ack;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_comb begin
      case ({avs_address[`CEIU_ADDR_W-1:2], 2'b00})
         `CEIU_OFF_CTRL: rd_mux = ctrl;
         `CEIU_OFF_STATUS: rd_mux = current_status_word;
         `CEIU_OFF_SAVED_FIQ: rd_mux = saved[0];
         `CEIU_OFF_SAVED_IRQ: rd_mux = saved[1];
         `CEIU_OFF_SAVED_ABT: rd_mux = saved[2];
         `CEIU_OFF_SAVED_SVC: rd_mux = saved[3];
         `CEIU_OFF_LINK_FIQ: rd_mux = link[0];
         `CEIU_OFF_LINK_IRQ: rd_mux = link[1];
         `CEIU_OFF_LINK_ABT: rd_mux = link[2];
         `CEIU_OFF_STATE: rd_mux = {26'h0000000, fiq_seen, irq_seen, int_pending,
            rst_sync_n, state};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         bus_ack <= (avs_read | avs_write) & ~bus_ack;
         if (avs_read & ~bus_ack) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Bit takes effect at once, hit_under_miss_disable one cycle later; the drain sequence is software's job
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl <= `CEIU_CTRL_RESET;
         hit_under_miss_disable <= 1'b0;
      end else if (ce) begin
         if (wr_now && {avs_address[`CEIU_ADDR_W-1:2], 2'b00} == `CEIU_OFF_CTRL) begin
            ctrl <= (ctrl & ~wmask) | (avs_writedata & wmask);
         end
         hit_under_miss_disable <= low_latency_enable;
      end
   end

   // Completion store from the handler becomes a pulse to the controller
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         vic_done <= 1'b0;
      end else if (ce) begin
         vic_done <= wr_now
            && {avs_address[`CEIU_ADDR_W-1:2], 2'b00} == `CEIU_OFF_VIC_DONE;
      end
   end
endmodule

// >>> rtl/ceiu_entry_arb.sv
// Purpose: picks which exception entry happens at an instruction boundary
// Assumes: requests are active high and already synchronised
// Notes: abort entry goes first so the fast handler chains right after it
`timescale 1ns/1ps
module ceiu_entry_arb (
   input wire logic boundary,
   input wire logic data_abort,
   input wire logic fiq_req,
   input wire logic irq_req,
   input wire logic fiq_mask,
   input wire logic irq_mask,
   input wire logic int_hold,
   output logic take_abt,
   output logic take_fiq,
   output logic take_irq
);
   always_comb begin
      take_abt = boundary & data_abort;
      take_fiq = boundary & ~data_abort & ~int_hold & fiq_req & ~fiq_mask;
      // Fast request wins over normal
      take_irq = boundary & ~data_abort & ~int_hold & irq_req & ~irq_mask
         & ~(fiq_req & ~fiq_mask);
   end
endmodule

// >>> rtl/ceiu_pkg.sv
// Purpose: types shared by the exception unit files
// Assumes: nothing
// Notes: constants live in ceiu_regs.svh
package ceiu_pkg;
   typedef enum logic [1:0] {
      S_RESET = 2'b00,
      S_RUN = 2'b01,
      S_CHAIN = 2'b10,
      S_VIC = 2'b11
   } ceiu_state_t;

   typedef enum logic [1:0] {
      BANK_FIQ = 2'b00,
      BANK_IRQ = 2'b01,
      BANK_ABT = 2'b10,
      BANK_SVC = 2'b11
   } ceiu_bank_t;
endpackage

// >>> rtl/ceiu_regs.svh
// Purpose: offsets, fields, reset values and vectors of the exception unit
// Assumes: byte addresses on the register bus, one 32-bit word per register
// Notes: definitions only
`ifndef CEIU_REGS_SVH
`define CEIU_REGS_SVH

`define CEIU_ADDR_W 6
`define CEIU_OFF_CTRL 6'h00
`define CEIU_OFF_STATUS 6'h04
`define CEIU_OFF_SAVED_FIQ 6'h08
`define CEIU_OFF_SAVED_IRQ 6'h0C
`define CEIU_OFF_SAVED_ABT 6'h10
`define CEIU_OFF_SAVED_SVC 6'h14
`define CEIU_OFF_LINK_FIQ 6'h18
`define CEIU_OFF_LINK_IRQ 6'h1C
`define CEIU_OFF_LINK_ABT 6'h20
`define CEIU_OFF_STATE 6'h24
`define CEIU_OFF_VIC_DONE 6'h28

`define CEIU_CTRL_LL_BIT 21
`define CEIU_CTRL_VE_BIT 24
`define CEIU_CTRL_RESET 32'h0000_0000

`define CEIU_ST_T_BIT 5
`define CEIU_ST_F_BIT 6
`define CEIU_ST_I_BIT 7
`define CEIU_ST_A_BIT 8
`define CEIU_ST_E_BIT 9
`define CEIU_ST_U_BIT 22
`define CEIU_ST_J_BIT 24
`define CEIU_ST_RESET 32'h0000_01D3

`define CEIU_MODE_FIQ 5'h11
`define CEIU_MODE_IRQ 5'h12
`define CEIU_MODE_SVC 5'h13
`define CEIU_MODE_ABT 5'h17

`define CEIU_VEC_RESET 32'h0000_0000
`define CEIU_VEC_DABT 32'h0000_0010
`define CEIU_VEC_IRQ 32'h0000_0018
`define CEIU_VEC_FIQ 32'h0000_001C
`define CEIU_LINK_OFS_INT 32'h0000_0004
`define CEIU_LINK_OFS_DABT 32'h0000_0008

`endif

// >>> rtl/ceiu_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: ce freezes the stages like all other state
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module ceiu_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta <= INIT;
         q <= INIT;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// >>> test/ceiu_core_chk.sv
// Purpose: concurrent checks on the exception unit ports
// Assumes: ce held high by the bench
// Notes: bound to every ceiu_core instance
`timescale 1ns/1ps
module ceiu_core_chk (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic core_reset_n,
   input wire logic big_endian_init_pin,
   input wire logic unaligned_enable_init_pin,
   input wire logic restartable_busy,
   input wire logic [31:0] vic_addr,
   input wire logic vic_addr_valid,
   input wire logic [5:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic [31:0] current_status_word,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic abandon_instr,
   input wire logic hit_under_miss_disable,
   input wire logic abandon_restartable,
   input wire logic int_pending,
   input wire logic vic_addr_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_reset_abandon: assert property (
      !core_reset_n [*3] |-> abandon_instr) else $error("core reset did not abandon");
   // Two sync flops plus the update edge, so the new word shows three or four edges on
   a_reset_release: assert property (
      !core_reset_n [*3] ##1 core_reset_n |-> ##[3:4] (fetch_req && fetch_addr == 32'h0
      && current_status_word[8:0] == 9'h1D3 && !current_status_word[24]
      && current_status_word[9] == big_endian_init_pin
      && current_status_word[22] == unaligned_enable_init_pin))
      else $error("bad state after core reset");
   a_fast_entry: assert property (
      fetch_req && fetch_addr == 32'h1C |-> current_status_word[4:0] == 5'h11
      && current_status_word[7:6] == 2'h3) else $error("bad fast entry status");
   // Fast mask may already be set by software; entry must leave it as it was
   a_normal_entry: assert property (
      fetch_req && fetch_addr == 32'h18 |-> current_status_word[4:0] == 5'h12
      && current_status_word[7] && current_status_word[6] == $past(current_status_word[6]))
      else $error("bad normal entry status");
   a_abort_chain: assert property (
      fetch_req && fetch_addr == 32'h10 && int_pending |-> ##[1:2]
      (fetch_req && fetch_addr == 32'h1C)) else $error("fast entry missing after abort");
   a_vic_entry: assert property (
      vic_addr_req && vic_addr_valid && !abandon_instr
      |=> fetch_req && fetch_addr == $past(vic_addr))
      else $error("vectored address not fetched");
   a_ll_abandon: assert property (
      abandon_restartable |-> int_pending && restartable_busy
      && (hit_under_miss_disable || $past(avs_write && !avs_waitrequest)))
      else $error("abandon without cause");
   a_ll_bit: assert property (
      avs_write && !avs_waitrequest && avs_address == 6'h00 && avs_byteenable[2]
      |-> ##2 hit_under_miss_disable == $past(avs_writedata[21], 2))
      else $error("low latency bit not applied");
   a_masks_block: assert property (
      current_status_word[6] && current_status_word[7] |-> !int_pending)
      else $error("pending while both masked");
   c_fast: cover property (fetch_req && fetch_addr == 32'h1C);
   c_vic: cover property (vic_addr_req && vic_addr_valid);
   c_abandon: cover property (abandon_restartable);
endmodule
bind ceiu_core ceiu_core_chk chk_u (.*);

// >>> test/ceiu_vic_model.sv
// Purpose: interrupt sources and vectored controller beside the core
// Assumes: bench tells which sources are active
// Notes: address bus toggles whenever it is not valid
`timescale 1ns/1ps
module ceiu_vic_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic fiq_on,
   input wire logic irq_on,
   input wire logic [3:0] delay,
   input wire logic [31:0] vec,
   input wire logic vic_addr_req,
   output logic fast_irq_request_n,
   output logic normal_irq_request_n,
   output logic [31:0] vic_addr,
   output logic vic_addr_valid
);
   logic [3:0] cnt;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fast_irq_request_n <= 1'b1;
         normal_irq_request_n <= 1'b1;
      end else begin
         fast_irq_request_n <= !fiq_on;
         normal_irq_request_n <= !irq_on;
      end
   end
   // Slow answers come from delay; stale data must never look valid
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt <= 4'h0;
         vic_addr_valid <= 1'b0;
         vic_addr <= 32'h0;
      end else begin
         vic_addr <= ~vic_addr;
         if (!vic_addr_req) begin
            cnt <= 4'h0;
            vic_addr_valid <= 1'b0;
         end else if (cnt >= delay) begin
            vic_addr_valid <= 1'b1;
            vic_addr <= vec;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// >>> test/testbench.sv
// Purpose: directed tests of exception entry, return and reset
// Assumes: one wait state on the register bus
// Notes: fetches are queued by a monitor and consumed in order
`timescale 1ns/1ps
`include "ceiu_regs.svh"
module testbench;
   logic sys_clk = 1'b0, reset = 1'b1, ce = 1'b1, core_reset_n = 1'b0;
   logic big_endian_init_pin = 1'b1, unaligned_enable_init_pin = 1'b0;
   logic instr_end = 1'b0, data_abort = 1'b0, mw_device_busy = 1'b0;
   logic ret_valid = 1'b0, ret_data_op = 1'b0, ret_set_flags = 1'b0, ret_dest_pc = 1'b0;
   logic restartable_busy = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic fiq_on = 1'b0, irq_on = 1'b0;
   logic [31:0] next_pc = 32'h0, abort_pc = 32'h0, avs_writedata = 32'h0, vec = 32'h0;
   logic [5:0] avs_address = 6'h00;
   logic [3:0] avs_byteenable = 4'hF, delay = 4'h0;
   logic fast_irq_request_n, normal_irq_request_n, vic_addr_valid, avs_waitrequest;
   logic fetch_req, abandon_instr, hit_under_miss_disable, abandon_restartable;
   logic int_pending, vic_addr_req, vic_ack, vic_done;
   logic [31:0] vic_addr, avs_readdata, current_status_word, fetch_addr;
   logic [31:0] fq[$];
   int n_mismatch = 0, checked = 0, cyc = 0, acks = 0, dones = 0;
   ceiu_core dut_u (.*);
   ceiu_vic_model vic_u (.*);
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (fetch_req === 1'b1) fq.push_back(fetch_addr);
      if (vic_ack === 1'b1) acks <= acks + 1;
      if (vic_done === 1'b1) dones <= dones + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         complete_run;
      end
   end
   task complete_run;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Waitrequest is read in the active region, so it is the pre-edge value
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rdc(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task bound(input logic [31:0] pc, input logic ab);
      @(posedge sys_clk);
      instr_end <= 1'b1;
      next_pc <= pc;
      data_abort <= ab;
      abort_pc <= pc;
      @(posedge sys_clk);
      instr_end <= 1'b0;
      data_abort <= 1'b0;
   endtask
   task fexp(input logic [31:0] e);
      for (int i = 0; i < 20 && fq.size() == 0; i++) @(posedge sys_clk);
      chk("fetch address", e, fq.size() > 0 ? fq.pop_front() : 32'hX);
   endtask
   task ret_op(input logic sf);
      @(posedge sys_clk);
      ret_valid <= 1'b1;
      ret_data_op <= 1'b1;
      ret_set_flags <= sf;
      ret_dest_pc <= 1'b1;
      @(posedge sys_clk);
      ret_valid <= 1'b0;
      clk(2);
   endtask
   initial begin
      clk(16);
      reset <= 1'b0;
      clk(4);
      chk("abandon", 1, abandon_instr);
      core_reset_n <= 1'b1;
      fexp(`CEIU_VEC_RESET);
      rdc(`CEIU_OFF_STATUS, 32'h0000_03D3);
      $display("test reset done");
      fiq_on <= 1'b1;
      clk(5);
      bound(32'h0000_0100, 1'b0);
      clk(10);
      chk("masked fetches", 0, fq.size());
      // Only the three mask bits may change from the bus
      wr(`CEIU_OFF_STATUS, 32'hFFFF_FE3F);
      rdc(`CEIU_OFF_STATUS, 32'h0000_0213);
      bound(32'h0000_0100, 1'b0);
      fexp(`CEIU_VEC_FIQ);
      rdc(`CEIU_OFF_STATUS, 32'h0000_02D1);
      rdc(`CEIU_OFF_LINK_FIQ, 32'h0000_0104);
      rdc(`CEIU_OFF_SAVED_FIQ, 32'h0000_0213);
      ret_op(1'b0);
      rdc(`CEIU_OFF_STATUS, 32'h0000_02D1);
      ret_op(1'b1);
      rdc(`CEIU_OFF_STATUS, 32'h0000_0213);
      irq_on <= 1'b1;
      clk(5);
      bound(32'h0000_0200, 1'b0);
      fexp(`CEIU_VEC_FIQ);
      fiq_on <= 1'b0;
      clk(5);
      ret_op(1'b1);
      bound(32'h0000_0200, 1'b0);
      fexp(`CEIU_VEC_IRQ);
      rdc(`CEIU_OFF_STATUS, 32'h0000_0292);
      rdc(`CEIU_OFF_LINK_IRQ, 32'h0000_0204);
      rdc(`CEIU_OFF_SAVED_IRQ, 32'h0000_0213);
      irq_on <= 1'b0;
      ret_op(1'b1);
      $display("test fast and normal done");
      fiq_on <= 1'b1;
      clk(5);
      bound(32'h0000_0300, 1'b1);
      fexp(`CEIU_VEC_DABT);
      fexp(`CEIU_VEC_FIQ);
      rdc(`CEIU_OFF_LINK_ABT, 32'h0000_0308);
      rdc(`CEIU_OFF_SAVED_ABT, 32'h0000_0213);
      rdc(`CEIU_OFF_LINK_FIQ, 32'h0000_0014);
      rdc(`CEIU_OFF_SAVED_FIQ, 32'h0000_0397);
      rdc(`CEIU_OFF_STATUS, 32'h0000_03D1);
      fiq_on <= 1'b0;
      clk(5);
      ret_op(1'b1);
      ret_op(1'b1);
      rdc(`CEIU_OFF_STATUS, 32'h0000_0213);
      $display("test abort chain done");
      fiq_on <= 1'b1;
      mw_device_busy <= 1'b1;
      clk(5);
      bound(32'h0000_0500, 1'b0);
      clk(10);
      chk("busy fetches", 0, fq.size());
      mw_device_busy <= 1'b0;
      bound(32'h0000_0500, 1'b0);
      fexp(`CEIU_VEC_FIQ);
      fiq_on <= 1'b0;
      clk(5);
      ret_op(1'b1);
      $display("test device transfer done");
      // Latency mode only changes with interrupts masked
      wr(`CEIU_OFF_STATUS, 32'h0000_01C0);
      wr(`CEIU_OFF_CTRL, 32'h0120_0000);
      wr(`CEIU_OFF_STATUS, 32'h0000_0000);
      clk(2);
      chk("hit under miss off", 1, hit_under_miss_disable);
      restartable_busy <= 1'b1;
      irq_on <= 1'b1;
      vec <= 32'h0000_4440;
      delay <= 4'h5;
      clk(5);
      chk("abandon restartable", 1, abandon_restartable);
      bound(32'h0000_0400, 1'b0);
      fexp(32'h0000_4440);
      clk(3);
      chk("entry acks", 1, acks);
      wr(`CEIU_OFF_VIC_DONE, 32'h0);
      clk(3);
      chk("done pulses", 1, dones);
      irq_on <= 1'b0;
      restartable_busy <= 1'b0;
      ret_op(1'b1);
      rdc(6'h3C, 32'h0);
      $display("test vectored done");
      core_reset_n <= 1'b0;
      big_endian_init_pin <= 1'b0;
      unaligned_enable_init_pin <= 1'b1;
      clk(6);
      chk("abandon", 1, abandon_instr);
      core_reset_n <= 1'b1;
      fexp(`CEIU_VEC_RESET);
      rdc(`CEIU_OFF_STATUS, 32'h0040_01D3);
      rdc(`CEIU_OFF_STATE, 32'h0000_0005);
      $display("test second reset done");
      complete_run;
   end
endmodule
